/* design/pep1_pkg.sv */
// Package of register map, field layout and timing constants for the page 1 register bank.
`default_nettype none
package pep1_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses are four times the register index)
    // ------------------------------------------------------------------
    localparam logic [4:0]  IDX_GOOD_CRC_CNT   = 5'h12;
    localparam logic [4:0]  IDX_EXT_MODE_CTRL  = 5'h13;
    localparam logic [4:0]  IDX_PWR_SAVE_CTRL  = 5'h14;
    localparam logic [4:0]  IDX_PAGE_SELECT    = 5'h1F;
    localparam logic [4:0]  IDX_EXT_LOW        = 5'h10;
    localparam logic [4:0]  IDX_EXT_HIGH       = 5'h1E;
    localparam logic [4:0]  IDX_CTRL_STATUS    = 5'h00;
    localparam logic [15:0] PAGE_MAIN          = 16'h0000;
    localparam logic [15:0] PAGE_EXT1          = 16'h0001;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          CRC_FLAG_BIT       = 15;
    localparam int          CRC_CNT_MSB        = 13;
    localparam int          LED_BLINK_BIT      = 11;
    localparam int          XOVER_LSB          = 2;
    localparam int          CAREXT_BIT         = 15;
    localparam int          SLEEP_LSB          = 13;
    localparam int          WAKE_LSB           = 11;
    localparam int          SOFT_RESET_BIT     = 15;
    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [13:0] CRC_CNT_WRAP       = 14'h270F;
    localparam logic        LED_BLINK_RST      = 1'h0;
    localparam logic [1:0]  XOVER_RST          = 2'h0;
    localparam logic        CAREXT_DIS_RST     = 1'h1;
    localparam logic [1:0]  SLEEP_RST          = 2'h1;
    localparam logic [1:0]  WAKE_RST           = 2'h0;
    localparam logic [1:0]  XOVER_AUTO         = 2'h0;
    localparam logic [1:0]  XOVER_RESERVED     = 2'h1;
    localparam logic [1:0]  XOVER_MDI          = 2'h2;
    localparam logic [1:0]  XOVER_MDIX         = 2'h3;
    // ------------------------------------------------------------------
    // Timer settings
    // ------------------------------------------------------------------
    localparam int          CLK_HZ             = 25000000;
    localparam int          TICK_US            = 1000;
    localparam int          TICK_CYCLES        = CLK_HZ / 1000000 * TICK_US;
    localparam logic [11:0] SLEEP_MS_1S        = 12'h3E8;
    localparam logic [11:0] SLEEP_MS_2S        = 12'h7D0;
    localparam logic [11:0] SLEEP_MS_3S        = 12'hBB8;
    localparam logic [11:0] SLEEP_MS_4S        = 12'hFA0;
    localparam logic [11:0] WAKE_MS_160        = 12'h0A0;
    localparam logic [11:0] WAKE_MS_400        = 12'h190;
    localparam logic [11:0] WAKE_MS_800        = 12'h320;
    localparam logic [11:0] WAKE_MS_2S         = 12'h7D0;
endpackage : pep1_pkg
`default_nettype wire

/* design/pep1_tick.sv */
// Millisecond tick divider and power-saving timers.
`default_nettype none
module pep1_tick
    import pep1_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Timer control
    input  wire logic [1:0]  sleep_sel_i,
    input  wire logic [1:0]  wake_sel_i,
    input  wire logic        idle_i,
    // Timer results
    output logic             sleep_due_o,
    output logic             wake_due_o
);
    typedef struct packed {
        logic [15:0] div;
        logic        tick;
        logic [11:0] sleep_ms;
        logic [11:0] wake_ms;
        logic        sleep_due;
        logic        wake_due;
    } pep1_tick_state_t;

    pep1_tick_state_t st;
    pep1_tick_state_t next_st;
    logic [11:0]      sleep_lim;
    logic [11:0]      wake_lim;

    always_comb begin
        case (sleep_sel_i) // R11
            2'h0:    sleep_lim = SLEEP_MS_1S;
            2'h1:    sleep_lim = SLEEP_MS_2S;
            2'h2:    sleep_lim = SLEEP_MS_3S;
            default: sleep_lim = SLEEP_MS_4S;
        endcase
        case (wake_sel_i) // R12
            2'h0:    wake_lim = WAKE_MS_160;
            2'h1:    wake_lim = WAKE_MS_400;
            2'h2:    wake_lim = WAKE_MS_800;
            default: wake_lim = WAKE_MS_2S;
        endcase
        next_st      = st;
        next_st.tick = 1'b0;
        if (st.div >= 16'(TICK_DIV - 1)) begin
            next_st.div  = 16'h0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.div = st.div + 16'h0001;
        end
        // Idle link counts toward sleep; an active link counts toward wake-up.
        if (!idle_i) begin
            next_st.sleep_ms  = 12'h000;
            next_st.sleep_due = 1'b0;
        end else if (st.tick && !st.sleep_due) begin
            next_st.sleep_ms  = st.sleep_ms + 12'h001;
            next_st.sleep_due = (st.sleep_ms + 12'h001) >= sleep_lim;
        end
        if (idle_i) begin
            next_st.wake_ms  = 12'h000;
            next_st.wake_due = 1'b0;
        end else if (st.tick && !st.wake_due) begin
            next_st.wake_ms  = st.wake_ms + 12'h001;
            next_st.wake_due = (st.wake_ms + 12'h001) >= wake_lim;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sleep_due_o = st.sleep_due;
    assign wake_due_o  = st.wake_due;
endmodule : pep1_tick
`default_nettype wire

/* design/pep1_regs.sv */
// Extended page 1 register bank of one PHY port behind an APB slave.
// Summary of operation
// R1 - Writing 0x0001 to register 31 maps addresses 16 to 30 onto the page 1 bank.
// R2 - Writing 0x0000 to register 31 maps addresses 16 to 30 back to the main bank.
// R3 - With page 1 selected, accesses to 16 to 30 act on page 1 registers only.
// R4 - Addresses 0 to 15 always reach the standard registers whatever the page.
// R5 - Bit 15 of the good-CRC counter shows a packet since the last read and clears on read.
// R6 - Bits 13:0 count good-CRC copper packets modulo 10000, wrapping after 9999.
// R7 - The good-CRC count clears on read and starts from zero after reset.
// R8 - Extended mode bit 11 at 1 lets LEDs blink after low-power hold release, 0 suppresses it.
// R9 - Extended mode bits 3:2 select auto, reserved, forced MDI or forced MDI-X crossover.
// R10 - Power control bit 15, default 1, disables carrier extension.
// R11 - Power control bits 14:13 pick a sleep timer of 1, 2, 3 or 4 s, default 2 s.
// R12 - Power control bits 12:11 pick a wake-up timer of 160, 400, 800 ms or 2 s, default 160 ms.
// R13 - Reserved bits and addresses read zero and ignore writes.
// R14 - Sticky fields survive a port software reset and reset only on hardware reset.
//
// Added by the designer: register access over APB.
`default_nettype none
module pep1_regs
    import pep1_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        NRST_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [6:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // Main-bank access for addresses outside page 1
    output logic             MAIN_SEL_O,
    output logic             MAIN_WRITE_O,
    output logic [4:0]       MAIN_ADDR_O,
    output logic [15:0]      MAIN_WDATA_O,
    input  wire logic [15:0] MAIN_RDATA_I,
    // Media events and port status
    input  wire logic        GOOD_CRC_PKT_I,
    input  wire logic        LOW_POWER_HOLD_INPUT_I,
    input  wire logic        LINK_IDLE_I,
    // Control outputs
    output logic             LED_WAKE_BLINK_SELECT_O,
    output logic             LED_BLINK_REQ_O,
    output logic [1:0]       CROSSOVER_FORCE_SELECT_O,
    output logic             CARRIER_EXT_DISABLE_O,
    output logic             SLEEP_DUE_O,
    output logic             WAKE_DUE_O
);
    typedef struct packed {
        logic        pkt_s1;
        logic        pkt_s2;
        logic        pkt_d;
        logic        hold_s1;
        logic        hold_s2;
        logic        hold_d;
        logic        idle_s1;
        logic        idle_s2;
        logic [15:0] page;
        logic        pkt_flag;
        logic [13:0] crc_cnt;
        logic        led_blink;
        logic [1:0]  xover;
        logic        carext_dis;
        logic [1:0]  sleep_sel;
        logic [1:0]  wake_sel;
        logic [31:0] prdata;
        logic        pready;
        logic        main_sel;
        logic        main_write;
        logic [4:0]  main_addr;
        logic [15:0] main_wdata;
        logic        blink_req;
        logic        sleep_due;
        logic        wake_due;
    } pep1_state_t;

    pep1_state_t st;
    pep1_state_t next_st;
    logic [1:0]  rst_sync;
    logic        rst_n;
    logic [4:0]  idx;
    logic        setup;
    logic        acc;
    logic        ext_hit;
    logic        pkt_evt;
    logic        sleep_due;
    logic        wake_due;
    logic [15:0] rd;

    // --------------------------------------------------------------
    // Reset synchroniser
    // --------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // --------------------------------------------------------------
    // Power-saving timers
    // --------------------------------------------------------------
    pep1_tick #(
        .TICK_DIV    (TICK_DIV)
    ) u_tick (
        .clk_i       (CLK_SYS_I),
        .rst_n_i     (rst_n),
        .sleep_sel_i (st.sleep_sel),
        .wake_sel_i  (st.wake_sel),
        .idle_i      (st.idle_s2),
        .sleep_due_o (sleep_due),
        .wake_due_o  (wake_due)
    );

    assign idx     = PADDR_I[6:2];
    assign setup   = PSEL_I && !PENABLE_I;
    assign acc     = PSEL_I && PENABLE_I && st.pready;
    assign ext_hit = (st.page == PAGE_EXT1) && (idx >= IDX_EXT_LOW) && (idx <= IDX_EXT_HIGH);
    assign pkt_evt = st.pkt_s2 && !st.pkt_d;

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    always_comb begin
        next_st         = st;
        next_st.pkt_s1  = GOOD_CRC_PKT_I;
        next_st.pkt_s2  = st.pkt_s1;
        next_st.pkt_d   = st.pkt_s2;
        next_st.hold_s1 = LOW_POWER_HOLD_INPUT_I;
        next_st.hold_s2 = st.hold_s1;
        next_st.hold_d  = st.hold_s2;
        next_st.idle_s1 = LINK_IDLE_I;
        next_st.idle_s2 = st.idle_s1;
        next_st.pready  = setup;
        next_st.main_sel = 1'b0;
        next_st.sleep_due = sleep_due;
        next_st.wake_due  = wake_due;
        // LED blink pulse on release of the low-power hold, when enabled.
        next_st.blink_req = st.hold_d && !st.hold_s2 && st.led_blink; // R8
        if (pkt_evt) begin
            next_st.pkt_flag = 1'b1; // R5
            next_st.crc_cnt  = (st.crc_cnt >= CRC_CNT_WRAP) ? 14'h0000
                                                             : st.crc_cnt + 14'h0001; // R6
        end
        // A counter read includes a packet of its own setup cycle.
        rd = 16'h0000;
        case (idx)
            IDX_GOOD_CRC_CNT:  rd = {next_st.pkt_flag, 1'b0, next_st.crc_cnt}; // R5
            IDX_EXT_MODE_CTRL: rd = {4'h0, st.led_blink, 7'h00, st.xover, 2'h0}; // R13
            IDX_PWR_SAVE_CTRL: rd = {st.carext_dis, st.sleep_sel, st.wake_sel, 11'h000};
            default:           rd = 16'h0000; // R13
        endcase
        if (setup) begin
            next_st.prdata = 32'h0000_0000;
            if (idx == IDX_PAGE_SELECT) begin
                next_st.prdata = {16'h0000, st.page};
            end else if (ext_hit) begin // R3
                next_st.prdata = {16'h0000, rd};
            end else begin
                // Main-bank requests are issued in setup; data returns in the access phase.
                next_st.main_sel   = 1'b1; // R4
                next_st.main_write = PWRITE_I;
                next_st.main_addr  = idx;
                next_st.main_wdata = PWDATA_I[15:0];
            end
        end
        if (acc && !PWRITE_I && ext_hit && idx == IDX_GOOD_CRC_CNT) begin
            // A packet landing on the read cycle starts the new count instead of being lost.
            next_st.pkt_flag = pkt_evt; // R5
            next_st.crc_cnt  = pkt_evt ? 14'h0001 : 14'h0000; // R7
        end
        if (acc && PWRITE_I) begin
            if (idx == IDX_PAGE_SELECT) begin
                next_st.page = PWDATA_I[15:0]; // R1 R2
            end else if (ext_hit) begin
                case (idx)
                    IDX_EXT_MODE_CTRL: begin
                        next_st.led_blink = PWDATA_I[LED_BLINK_BIT]; // R8
                        next_st.xover     = PWDATA_I[XOVER_LSB +: 2]; // R9
                    end
                    IDX_PWR_SAVE_CTRL: begin
                        next_st.carext_dis = PWDATA_I[CAREXT_BIT]; // R10
                        next_st.sleep_sel  = PWDATA_I[SLEEP_LSB +: 2]; // R11
                        next_st.wake_sel   = PWDATA_I[WAKE_LSB +: 2]; // R12
                    end
                    default: ; // R13
                endcase
            end else if (idx == IDX_CTRL_STATUS && PWDATA_I[SOFT_RESET_BIT]) begin
                // Port software reset clears volatile state only; sticky fields remain.
                next_st.pkt_flag = pkt_evt; // R14
                next_st.crc_cnt  = pkt_evt ? 14'h0001 : 14'h0000;
                next_st.xover    = XOVER_RST;
            end
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            st.pkt_s1     <= 1'b0;
            st.pkt_s2     <= 1'b0;
            st.pkt_d      <= 1'b0;
            st.hold_s1    <= 1'b0;
            st.hold_s2    <= 1'b0;
            st.hold_d     <= 1'b0;
            st.idle_s1    <= 1'b0;
            st.idle_s2    <= 1'b0;
            st.page       <= PAGE_MAIN;
            st.pkt_flag   <= 1'b0;
            st.crc_cnt    <= 14'h0000; // R7
            st.led_blink  <= LED_BLINK_RST;
            st.xover      <= XOVER_RST;
            st.carext_dis <= CAREXT_DIS_RST; // R14
            st.sleep_sel  <= SLEEP_RST;
            st.wake_sel   <= WAKE_RST;
            st.prdata     <= 32'h0000_0000;
            st.pready     <= 1'b0;
            st.main_sel   <= 1'b0;
            st.main_write <= 1'b0;
            st.main_addr  <= 5'h00;
            st.main_wdata <= 16'h0000;
            st.blink_req  <= 1'b0;
            st.sleep_due  <= 1'b0;
            st.wake_due   <= 1'b0;
        end else begin
            st.pkt_s1     <= next_st.pkt_s1;
            st.pkt_s2     <= next_st.pkt_s2;
            st.pkt_d      <= next_st.pkt_d;
            st.hold_s1    <= next_st.hold_s1;
            st.hold_s2    <= next_st.hold_s2;
            st.hold_d     <= next_st.hold_d;
            st.idle_s1    <= next_st.idle_s1;
            st.idle_s2    <= next_st.idle_s2;
            st.page       <= next_st.page;
            st.pkt_flag   <= next_st.pkt_flag;
            st.crc_cnt    <= next_st.crc_cnt;
            st.led_blink  <= next_st.led_blink;
            st.xover      <= next_st.xover;
            st.carext_dis <= next_st.carext_dis;
            st.sleep_sel  <= next_st.sleep_sel;
            st.wake_sel   <= next_st.wake_sel;
            st.prdata     <= next_st.prdata;
            st.pready     <= next_st.pready;
            st.main_sel   <= next_st.main_sel;
            st.main_write <= next_st.main_write;
            st.main_addr  <= next_st.main_addr;
            st.main_wdata <= next_st.main_wdata;
            st.blink_req  <= next_st.blink_req;
            st.sleep_due  <= next_st.sleep_due;
            st.wake_due   <= next_st.wake_due;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    // Main-bank read data is muxed in only while the registered select is high.
    assign PRDATA_O                 = st.main_sel ? {16'h0000, MAIN_RDATA_I} : st.prdata;
    assign PREADY_O                 = st.pready;
    assign PSLVERR_O                = 1'b0;
    assign MAIN_SEL_O               = st.main_sel;
    assign MAIN_WRITE_O             = st.main_write;
    assign MAIN_ADDR_O              = st.main_addr;
    assign MAIN_WDATA_O             = st.main_wdata;
    assign LED_WAKE_BLINK_SELECT_O  = st.led_blink;
    assign LED_BLINK_REQ_O          = st.blink_req;
    assign CROSSOVER_FORCE_SELECT_O = st.xover; // R9
    assign CARRIER_EXT_DISABLE_O    = st.carext_dis; // R10
    assign SLEEP_DUE_O              = st.sleep_due;
    assign WAKE_DUE_O               = st.wake_due;
endmodule : pep1_regs
`default_nettype wire

/* testbench/pep1_main_bank.sv */
// Behavioural model of the main register bank that faces the page 1 bank.
`default_nettype none
module pep1_main_bank (
    // Clock
    input  wire logic        clk_i,
    // Main-bank access
    input  wire logic        sel_i,
    input  wire logic        write_i,
    input  wire logic [4:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    output logic [15:0]      rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [32] = '{default: 16'h0000};
    logic [15:0] junk     = 16'h5A5A;
    // Unselected cycles show a pattern that flips every cycle.
    assign rdata_o = sel_i ? mem[addr_i] : junk;
    always @(posedge clk_i) begin
        junk <= ~junk;
        if (sel_i && write_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
endmodule : pep1_main_bank
`default_nettype wire

/* testbench/pep1_regs_assertions.sv */
// Concurrent checks on the ports of the page 1 register bank.
`default_nettype none
module pep1_regs_chk (
    // Clock, reset and APB
    input wire logic        CLK_SYS_I,
    input wire logic        NRST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [6:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    // Main bank and controls
    input wire logic        MAIN_SEL_O,
    input wire logic [4:0]  MAIN_ADDR_O,
    input wire logic        LED_WAKE_BLINK_SELECT_O,
    input wire logic        LED_BLINK_REQ_O,
    input wire logic [1:0]  CROSSOVER_FORCE_SELECT_O,
    input wire logic        CARRIER_EXT_DISABLE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0]     page;
    wire logic [4:0] idx   = PADDR_I[6:2];
    wire logic       setup = PSEL_I && !PENABLE_I;
    wire logic       wr    = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    wire logic       rd    = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I;
    wire logic       p1    = page == 16'h0001;
    wire logic       hi    = idx >= 5'h10 && idx <= 5'h1E;
    // Mirrors the page select register as the host writes it.
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            page <= 16'h0000;
        end else if (wr && idx == 5'h1F) begin
            page <= PWDATA_I[15:0];
        end
    end
    default clocking dck @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!NRST_I);
    a_ready_next: assert property (setup |=> PREADY_O)
        else $error("ready missing");
    a_low_main: assert property (
        setup && idx < 5'h10 |=> MAIN_SEL_O && MAIN_ADDR_O == $past(idx))
        else $error("low address not forwarded");
    a_page_ext: assert property (setup && p1 && hi |=> !MAIN_SEL_O)
        else $error("page 1 access forwarded");
    a_page_main: assert property (setup && !p1 && hi |=> MAIN_SEL_O)
        else $error("main access not forwarded");
    a_mode_write: assert property (
        wr && p1 && idx == 5'h13 |=> LED_WAKE_BLINK_SELECT_O == $past(PWDATA_I[11])
        && CROSSOVER_FORCE_SELECT_O == $past(PWDATA_I[3:2]))
        else $error("mode fields not taken");
    a_carrier_write: assert property (
        wr && p1 && idx == 5'h14 |=> CARRIER_EXT_DISABLE_O == $past(PWDATA_I[15]))
        else $error("carrier field not taken");
    a_count_range: assert property (
        rd && p1 && idx == 5'h12 |-> PRDATA_O[13:0] <= 14'h270F
        && PRDATA_O[31:16] == 16'h0000 && !PRDATA_O[14])
        else $error("counter read out of range");
    a_mode_resv: assert property (
        rd && p1 && idx == 5'h13 |-> PRDATA_O[31:12] == 20'h00000
        && PRDATA_O[10:4] == 7'h00 && PRDATA_O[1:0] == 2'h0)
        else $error("reserved mode bits set");
    a_blink_gate: assert property (
        LED_BLINK_REQ_O |-> LED_WAKE_BLINK_SELECT_O ##1 !LED_BLINK_REQ_O)
        else $error("blink request wrong");
    a_sticky_keep: assert property (
        wr && idx == 5'h00 && PWDATA_I[15] |=> $stable(LED_WAKE_BLINK_SELECT_O)
        && $stable(CARRIER_EXT_DISABLE_O))
        else $error("sticky field lost");
endmodule : pep1_regs_chk
bind pep1_regs pep1_regs_chk pep1_regs_chk_inst (
    .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .MAIN_SEL_O(MAIN_SEL_O), .MAIN_ADDR_O(MAIN_ADDR_O),
    .LED_WAKE_BLINK_SELECT_O(LED_WAKE_BLINK_SELECT_O), .LED_BLINK_REQ_O(LED_BLINK_REQ_O),
    .CROSSOVER_FORCE_SELECT_O(CROSSOVER_FORCE_SELECT_O),
    .CARRIER_EXT_DISABLE_O(CARRIER_EXT_DISABLE_O)
);
`default_nettype wire

/* testbench/test_pep1_regs.sv */
// Testbench of the page 1 register bank against a main-bank model.
`default_nettype none
module test_pep1_regs;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [4:0] a; logic [15:0] d, e;} pep1_row_t;
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        pkt = 1'b0, hold = 1'b0, idle = 1'b0;
    logic [6:0]  paddr = 7'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, msel, mwr, blink, carrier, sleep_due, wake_due, slverr;
    logic [4:0]  maddr;
    logic [15:0] mwd, mrd;
    int          fails = 0, cmp_count = 0, cyc = 0, n;
    pep1_row_t   rows [27] = '{
        '{1'b1,5'h1F,16'h0001,16'h0000}, '{1'b0,5'h14,16'h0000,16'hA000},
        '{1'b1,5'h13,16'hFFFF,16'h0000}, '{1'b0,5'h13,16'h0000,16'h080C},
        '{1'b1,5'h13,16'h0004,16'h0000}, '{1'b0,5'h13,16'h0000,16'h0004},
        '{1'b1,5'h13,16'h0008,16'h0000}, '{1'b0,5'h13,16'h0000,16'h0008},
        '{1'b1,5'h14,16'h7800,16'h0000}, '{1'b0,5'h14,16'h0000,16'h7800},
        '{1'b1,5'h14,16'hCFFF,16'h0000}, '{1'b0,5'h14,16'h0000,16'hC800},
        '{1'b1,5'h14,16'h9000,16'h0000}, '{1'b0,5'h14,16'h0000,16'h9000},
        '{1'b1,5'h10,16'h1234,16'h0000}, '{1'b0,5'h10,16'h0000,16'h0000},
        '{1'b1,5'h05,16'hBEEF,16'h0000}, '{1'b0,5'h05,16'h0000,16'hBEEF},
        '{1'b1,5'h1F,16'h0000,16'h0000}, '{1'b1,5'h10,16'h5555,16'h0000},
        '{1'b0,5'h10,16'h0000,16'h5555}, '{1'b1,5'h1F,16'h0002,16'h0000},
        '{1'b0,5'h10,16'h0000,16'h5555}, '{1'b0,5'h1F,16'h0000,16'h0002},
        '{1'b1,5'h1F,16'h0001,16'h0000}, '{1'b0,5'h10,16'h0000,16'h0000},
        '{1'b0,5'h13,16'h0000,16'h0008}};
    always #20 clk = ~clk;
    pep1_regs #(.TICK_DIV(4)) pep1_regs_inst (
        .CLK_SYS_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(slverr), .MAIN_SEL_O(msel), .MAIN_WRITE_O(mwr), .MAIN_ADDR_O(maddr),
        .MAIN_WDATA_O(mwd), .MAIN_RDATA_I(mrd), .GOOD_CRC_PKT_I(pkt),
        .LOW_POWER_HOLD_INPUT_I(hold), .LINK_IDLE_I(idle), .LED_WAKE_BLINK_SELECT_O(),
        .LED_BLINK_REQ_O(blink), .CROSSOVER_FORCE_SELECT_O(),
        .CARRIER_EXT_DISABLE_O(carrier), .SLEEP_DUE_O(sleep_due), .WAKE_DUE_O(wake_due));
    pep1_main_bank pep1_main_bank_inst (.clk_i(clk), .sel_i(msel), .write_i(mwr),
        .addr_i(maddr), .wdata_i(mwd), .rdata_o(mrd));
    task automatic final_report();
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {a, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic pulses(input int cnt);
        repeat (cnt) begin
            @(posedge clk);
            pkt <= 1'b1;
            repeat (2) @(posedge clk);
            pkt <= 1'b0;
            @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask : pulses
    task automatic wait_due(input logic wk, input int lim);
        n = 0;
        while ((wk ? wake_due : sleep_due) !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_due
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            fails++;
            $display("[ERR] %0t timeout", $time);
            final_report();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) begin
                check(rd, {16'h0000, rows[i].e});
            end
        end
        pulses(3);
        apb(1'b0, 5'h12, 16'h0000);
        check(rd, 32'h0000_8003);
        apb(1'b0, 5'h12, 16'h0000);
        check(rd, 32'h0000_0000);
        pulses(10001);
        apb(1'b0, 5'h12, 16'h0000);
        check(rd, 32'h0000_8001);
        // A port soft reset drops the count but keeps the sticky fields.
        apb(1'b1, 5'h13, 16'h0808);
        pulses(1);
        apb(1'b1, 5'h00, 16'h8000);
        apb(1'b0, 5'h12, 16'h0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, 5'h13, 16'h0000);
        check(rd, 32'h0000_0800);
        apb(1'b0, 5'h14, 16'h0000);
        check(rd, 32'h0000_9000);
        for (int k = 1; k >= 0; k--) begin
            apb(1'b1, 5'h13, k[0] ? 16'h0800 : 16'h0000);
            hold <= 1'b1;
            repeat (4) @(posedge clk);
            hold <= 1'b0;
            n = 0;
            repeat (8) begin
                @(posedge clk);
                n += int'(blink === 1'b1);
            end
            check(32'(n), 32'(k));
        end
        apb(1'b1, 5'h14, 16'h0000);
        idle <= 1'b1;
        wait_due(1'b0, 4100);
        check(32'(n > 3980 && n < 4100), 32'h1);
        idle <= 1'b0;
        wait_due(1'b1, 700);
        check(32'(n > 630 && n < 700), 32'h1);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        check({31'h0, carrier}, 32'h1);
        apb(1'b1, 5'h1F, 16'h0001);
        apb(1'b0, 5'h14, 16'h0000);
        check(rd, 32'h0000_A000);
        apb(1'b0, 5'h13, 16'h0000);
        check(rd, 32'h0000_0000);
        check({31'h0, slverr}, 32'h0);
        final_report();
    end
endmodule : test_pep1_regs
`default_nettype wire
